/* File: hw/sas_pkg.sv */
// Shared constants and types for the converter sequencer
// Function
// RL1: Channel code 0-12 routes input; above floats
// RL2: Start bit reads one while converting
// RL3: Bit zero enables the converter
// RL4: Negative reference from input 2 or ground
// RL5: Positive reference from input 3 or supply
// RL6: Pin field turns pins digital from top
// RL7: Power-on pin bits follow port fuse
// RL8: Justify bit picks right or left result
// RL9: Acquisition code maps to clock periods
// RL10: Clock code picks divider or RC clock
// RL11: RC clock starts one instruction late
// RL12: Conversion continues in sleep on RC
// RL13: Result built by successive approximation
// RL14: Reset clears registers and aborts conversion
// RL15: Finish writes result, clears start, flags
// RL16: Result pair untouched by reset
// RL17: Acquisition inserted before conversion start
// RL18: Two clock periods hold-off after conversion
// RL19: Holding capacitor disconnects at conversion start
// RL20: Each conversion yields ten-bit value
// RL21: Software polls or waits before reading
// RL22: Software configures, enables, then starts
// RL23: Full conversion takes eleven clock periods
// RL24: Clearing start aborts, result kept
// RL25: Sampling continues then converts automatically
// RL26: Sampling resumes after conversion completes
// RL27: Timing counted in conversion clock periods
// RL28: Unimplemented bits read zero
package sas_pkg;
  // Register offsets
  localparam logic [2:0] SAS_OFF_CTRL    = 3'h0;
  localparam logic [2:0] SAS_OFF_REFPIN  = 3'h1;
  localparam logic [2:0] SAS_OFF_TIMING  = 3'h2;
  localparam logic [2:0] SAS_OFF_RES_HI  = 3'h3;
  localparam logic [2:0] SAS_OFF_RES_LO  = 3'h4;
  localparam logic [2:0] SAS_OFF_FLAG    = 3'h5;
  // Field positions
  localparam int SAS_CTRL_ON    = 0;
  localparam int SAS_CTRL_GO    = 1;
  localparam int SAS_CTRL_CHLO  = 2;
  localparam int SAS_REF_NEG    = 5;
  localparam int SAS_REF_POS    = 4;
  localparam int SAS_TIM_JUST   = 7;
  localparam int SAS_TIM_ACQLO  = 3;
  // Reset values and masks
  localparam logic [7:0] SAS_CTRL_MASK  = 8'h3F;
  localparam logic [7:0] SAS_REF_MASK   = 8'h3F;
  localparam logic [7:0] SAS_TIM_MASK   = 8'hBF;
  localparam logic [7:0] SAS_RST_ZERO   = 8'h00;
  localparam logic [2:0] SAS_PCFG_ANA   = 3'h0;
  localparam logic [2:0] SAS_PCFG_DIG   = 3'h7;
  // Counts in conversion clock periods, then highest sampled channel code
  localparam logic [4:0] SAS_HOLDOFF_TAD = 5'h02;
  localparam logic [3:0] SAS_CONV_TAD    = 4'hB;
  localparam logic [3:0] SAS_NUM_CH      = 4'hC;
  // Instruction cycle delay in system clocks (four oscillator clocks)
  localparam int         SAS_TCY_NS      = 32;
  localparam int         SAS_CLK_NS      = 8;
  localparam logic [2:0] SAS_TCY_CYC     = 3'((SAS_TCY_NS + SAS_CLK_NS - 1) / SAS_CLK_NS);
  // Sequencer states
  typedef enum logic [2:0] {SAS_IDLE, SAS_DELAY, SAS_ACQ, SAS_CONV, SAS_HOLD} sas_state_type;

  // Acquisition code to period count
  function automatic logic [4:0] sas_acq_len(input logic [2:0] code);
    unique case (code)
      3'h7: sas_acq_len = 5'h14;
      3'h6: sas_acq_len = 5'h10;
      3'h5: sas_acq_len = 5'h0C;
      3'h4: sas_acq_len = 5'h08;
      3'h3: sas_acq_len = 5'h06;
      3'h2: sas_acq_len = 5'h04;
      3'h1: sas_acq_len = 5'h02;
      3'h0: sas_acq_len = 5'h00;
    endcase
  endfunction
endpackage

/* File: hw/sas_tick_if.sv */
// Conversion clock tick carrier between divider and sequencer
`timescale 1ns/1ps
interface sas_tick_if;
  logic [2:0] sel;   // Conversion clock code
  logic       run;   // Tick generation allowed
  logic       tick;  // One pulse per conversion clock period
  logic       i_rc_tick; // Raw RC oscillator level
  modport gen (input sel, input run, input i_rc_tick, output tick);
  modport use_ (output sel, output run, input tick);
endinterface

/* File: hw/sas_clkdiv.sv */
// Conversion clock divider: system divide or synchronised RC ticks
`timescale 1ns/1ps
module sas_clkdiv
  import sas_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Tick carrier
  sas_tick_if.gen   tk
);
  logic [5:0] cnt_q;   // Divider count
  logic [5:0] top;     // Terminal count
  logic [2:0] rc_q;    // RC edge sync and history
  logic       rc_edge; // RC rising edge

  ////////////////////////////////////////////////////////////////
  // Divider terminal count per code
  always_comb
  begin
    unique case (tk.sel)
      3'h0: top = 6'h01; // RL10
      3'h1: top = 6'h07;
      3'h2: top = 6'h1F;
      3'h4: top = 6'h03;
      3'h5: top = 6'h0F;
      3'h6: top = 6'h3F;
      default: top = 6'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // RC oscillator two-stage sync, third stage for edge
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rc_q <= 3'h0;
    else
      rc_q <= {rc_q[1:0], tk.i_rc_tick};
  end
  assign rc_edge = rc_q[1] & ~rc_q[2];

  ////////////////////////////////////////////////////////////////
  // Divider counter
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_q <= 6'h00;
    else if (!tk.run || cnt_q == top)
      cnt_q <= 6'h00;
    else
      cnt_q <= cnt_q + 6'h01;
  end

  // Tick from RC for x11 codes, divider otherwise
  assign tk.tick = tk.run & ((tk.sel[1:0] == 2'h3) ? rc_edge : (cnt_q == top)); // RL12
endmodule

/* File: hw/sas_sar.sv */
// Successive approximation register, one bit per tick
`timescale 1ns/1ps
module sas_sar
  import sas_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_start,
  input  wire logic       i_step,
  input  wire logic       i_cmp,
  // Trial and result
  output logic      [9:0] o_trial,
  output logic      [9:0] o_code
);
  logic [9:0] code_q; // Resolved bits
  logic [9:0] bit_q;  // Bit under trial

  ////////////////////////////////////////////////////////////////
  // Bit-by-bit decision, MSB first
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      code_q <= 10'h000;
      bit_q  <= 10'h000;
    end
    else if (i_start)
    begin
      code_q <= 10'h000;
      bit_q  <= 10'h200;
    end
    else if (i_step && bit_q != 10'h000)
    begin
      if (i_cmp)
        code_q <= code_q | bit_q; // RL13
      bit_q <= bit_q >> 1;
    end
  end
  assign o_trial = code_q | bit_q;
  assign o_code  = code_q;
endmodule

/* File: hw/sas_top.sv */
// Converter sequencer top: registers, sequencing, analog controls
`timescale 1ns/1ps
module sas_top
  import sas_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Power-on strap
  input  wire logic       i_portb_analog_fuse,
  input  wire logic       i_por,
  // Register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Analog side
  input  wire logic       i_rc_osc,
  input  wire logic       i_cmp,
  output logic      [9:0] o_dac_code,
  output logic      [3:0] o_channel_select,
  output logic            o_sample,
  output logic            o_neg_ref_select,
  output logic            o_pos_ref_select,
  output logic     [12:0] o_pin_analog,
  output logic            o_conv_done_flag
);
  ////////////////////////////////////////////////////////////////
  // Declarations
  sas_tick_if      tk();
  sas_state_type   st_q;          // Sequencer state
  logic      [7:0] ctrl_q;        // Channel and control register
  logic      [7:0] ref_q;         // Reference and pin register
  logic      [7:0] tim_q;         // Timing and format register
  logic      [9:0] res_q;         // Last completed result
  logic            flag_q;        // Done flag
  logic      [4:0] tcnt_q;        // Period counter
  logic      [2:0] dly_q;         // Instruction delay counter
  logic      [7:0] rdata_q;       // Read data register
  logic            por_q;         // Strap capture pending
  logic      [1:0] cmp_q;         // Comparator sync
  logic      [1:0] fz_q;          // Fuse sync
  logic      [1:0] porz_q;        // Power-on pulse sync
  logic      [1:0] fill_q;        // Synchronisers filled since reset
  logic            go;            // Start bit
  logic            on;            // Converter enabled
  logic            go_set;        // Software sets start
  logic            go_clr;        // Software clears start
  logic            done;          // Conversion finished
  logic      [9:0] code;          // Resolved code
  logic            sar_start;     // Load SAR
  logic            is_rc;         // RC clock selected
  logic     [15:0] res_just;      // Justified result

  assign go = ctrl_q[SAS_CTRL_GO];
  assign on = ctrl_q[SAS_CTRL_ON];
  assign is_rc = (tim_q[1:0] == 2'h3);
  assign go_set = i_wr && i_addr == SAS_OFF_CTRL && i_wdata[SAS_CTRL_GO] && !go;
  assign go_clr = i_wr && i_addr == SAS_OFF_CTRL && !i_wdata[SAS_CTRL_GO];

  ////////////////////////////////////////////////////////////////
  // Input synchronisers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cmp_q  <= 2'h0;
      fz_q   <= 2'h0;
      porz_q <= 2'h0;
      fill_q <= 2'h0;
    end
    else
    begin
      cmp_q  <= {cmp_q[0], i_cmp};
      fz_q   <= {fz_q[0], i_portb_analog_fuse};
      porz_q <= {porz_q[0], i_por};
      fill_q <= {fill_q[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Tick generator and SAR
  assign tk.sel = tim_q[2:0];
  // Ticks also run in the delay, so an RC start lands on a period edge
  assign tk.run = (st_q != SAS_IDLE);
  assign tk.i_rc_tick = i_rc_osc;

  sas_clkdiv u_div
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .tk      (tk)
  );

  assign sar_start = (st_q != SAS_CONV) && (
                     (st_q == SAS_ACQ && tk.tick && tcnt_q <= 5'h01) ||
                     (st_q == SAS_IDLE && go && on &&
                      sas_acq_len(tim_q[5:3]) == 5'h00 && !is_rc) ||
                     (st_q == SAS_DELAY && dly_q == 3'h0 && tk.tick &&
                      sas_acq_len(tim_q[5:3]) == 5'h00));

  sas_sar u_sar
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_start (sar_start),
    .i_step  (st_q == SAS_CONV && tk.tick),
    .i_cmp   (cmp_q[1]),
    .o_trial (o_dac_code),
    .o_code  (code)
  );

  ////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q   <= SAS_IDLE; // RL14
      tcnt_q <= 5'h00;
      dly_q  <= 3'h0;
    end
    else if (!on || (go_clr && st_q != SAS_HOLD && st_q != SAS_IDLE))
    begin
      st_q   <= on ? SAS_HOLD : SAS_IDLE; // RL24
      tcnt_q <= SAS_HOLDOFF_TAD;
    end
    else
    begin
      unique case (st_q)
        SAS_IDLE:
          if (go)
          begin
            if (is_rc)
            begin
              st_q  <= SAS_DELAY; // RL11
              dly_q <= SAS_TCY_CYC - 3'h1;
            end
            else if (sas_acq_len(tim_q[5:3]) != 5'h00)
            begin
              st_q   <= SAS_ACQ; // RL17
              tcnt_q <= sas_acq_len(tim_q[5:3]); // RL9
            end
            else
            begin
              st_q   <= SAS_CONV; // RL19
              tcnt_q <= {1'b0, SAS_CONV_TAD};
            end
          end
        SAS_DELAY:
          if (dly_q != 3'h0)
            dly_q <= dly_q - 3'h1;
          else if (tk.tick)
          begin
            // Start on an RC edge so the first period is whole
            if (sas_acq_len(tim_q[5:3]) != 5'h00)
            begin
              st_q   <= SAS_ACQ;
              tcnt_q <= sas_acq_len(tim_q[5:3]);
            end
            else
            begin
              st_q   <= SAS_CONV;
              tcnt_q <= {1'b0, SAS_CONV_TAD};
            end
          end
        SAS_ACQ:
          if (tk.tick)
          begin
            if (tcnt_q <= 5'h01)
            begin
              st_q   <= SAS_CONV; // RL25
              tcnt_q <= {1'b0, SAS_CONV_TAD};
            end
            else
              tcnt_q <= tcnt_q - 5'h01; // RL27
          end
        SAS_CONV:
          if (tk.tick)
          begin
            if (tcnt_q <= 5'h01)
            begin
              st_q   <= SAS_HOLD; // RL23
              tcnt_q <= SAS_HOLDOFF_TAD;
            end
            else
              tcnt_q <= tcnt_q - 5'h01;
          end
        SAS_HOLD:
          if (tk.tick)
          begin
            if (tcnt_q <= 5'h01)
              st_q <= SAS_IDLE; // RL18
            else
              tcnt_q <= tcnt_q - 5'h01;
          end
      endcase
    end
  end

  assign done = (st_q == SAS_CONV) && tk.tick && tcnt_q <= 5'h01 && !go_clr;

  ////////////////////////////////////////////////////////////////
  // Control register: channel, start, enable
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ctrl_q <= SAS_RST_ZERO; // RL14
    else if (done)
    begin
      ctrl_q[SAS_CTRL_GO] <= 1'b0; // RL15
      if (i_wr && i_addr == SAS_OFF_CTRL)
        ctrl_q <= i_wdata & SAS_CTRL_MASK & ~8'h02;
    end
    else if (i_wr && i_addr == SAS_OFF_CTRL)
    begin
      ctrl_q <= i_wdata & SAS_CTRL_MASK; // RL3
      if (go_set && (st_q != SAS_IDLE || !on))
        ctrl_q[SAS_CTRL_GO] <= 1'b0; // RL2
    end
    else if (!on)
      ctrl_q[SAS_CTRL_GO] <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Reference and pin register, strap caught after power-on
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ref_q <= SAS_RST_ZERO;
      por_q <= 1'b1;
    end
    // Capture only once the fuse sync holds a real level
    else if ((por_q && fill_q[1]) || porz_q[1])
    begin
      ref_q <= {5'h00, fz_q[1] ? SAS_PCFG_ANA : SAS_PCFG_DIG}; // RL7
      por_q <= 1'b0;
    end
    else if (i_wr && i_addr == SAS_OFF_REFPIN)
      ref_q <= i_wdata & SAS_REF_MASK;
  end

  ////////////////////////////////////////////////////////////////
  // Timing and format register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tim_q <= SAS_RST_ZERO;
    else if (i_wr && i_addr == SAS_OFF_TIMING)
      tim_q <= i_wdata & SAS_TIM_MASK; // RL28
  end

  ////////////////////////////////////////////////////////////////
  // Result pair: no reset, software may also write
  always_ff @(posedge i_clk)
  begin
    if (done)
      res_q <= code; // RL20
    else if (i_wr && i_addr == SAS_OFF_RES_HI)
      res_q <= tim_q[SAS_TIM_JUST] ? {i_wdata[1:0], res_q[7:0]}
                                   : {i_wdata, res_q[1:0]};
    else if (i_wr && i_addr == SAS_OFF_RES_LO)
      res_q <= tim_q[SAS_TIM_JUST] ? {res_q[9:8], i_wdata}
                                   : {res_q[9:2], i_wdata[7:6]};
  end // RL16

  ////////////////////////////////////////////////////////////////
  // Done flag, set wins over clear
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      flag_q <= 1'b0;
    else if (done)
      flag_q <= 1'b1; // RL15
    else if (i_wr && i_addr == SAS_OFF_FLAG)
      flag_q <= i_wdata[0];
  end

  ////////////////////////////////////////////////////////////////
  // Read data, one cycle after strobe
  assign res_just = tim_q[SAS_TIM_JUST] ? {6'h00, res_q} : {res_q, 6'h00}; // RL8
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_q <= 8'h00;
    else if (i_rd)
    begin
      unique case (i_addr)
        SAS_OFF_CTRL:   rdata_q <= ctrl_q; // RL2
        SAS_OFF_REFPIN: rdata_q <= ref_q;
        SAS_OFF_TIMING: rdata_q <= tim_q;
        SAS_OFF_RES_HI: rdata_q <= res_just[15:8];
        SAS_OFF_RES_LO: rdata_q <= res_just[7:0];
        SAS_OFF_FLAG:   rdata_q <= {7'h00, flag_q};
        default:        rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end
  assign o_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////
  // Analog controls
  assign o_channel_select = ctrl_q[5:2]; // RL1
  assign o_sample = on && ctrl_q[5:2] <= SAS_NUM_CH && st_q != SAS_CONV
                    && st_q != SAS_HOLD; // RL26
  assign o_neg_ref_select = ref_q[SAS_REF_NEG]; // RL4
  assign o_pos_ref_select = ref_q[SAS_REF_POS]; // RL5
  assign o_conv_done_flag = flag_q;
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++)
    begin : g_pin
      assign o_pin_analog[gi] = ({1'b0, ref_q[3:0]} < 5'(15 - gi)) ||
                                (ref_q[3:0] <= 4'h2); // RL6
    end
  endgenerate
endmodule

/* File: bench/sas_top_props.sv */
// Port-level assertions for the converter sequencer top
`timescale 1ns/1ps
module sas_top_props
  import sas_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Register port
  input wire logic [2:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  // Analog side
  input wire logic [3:0]  o_channel_select,
  input wire logic        o_sample,
  input wire logic        o_neg_ref_select,
  input wire logic        o_pos_ref_select,
  input wire logic [12:0] o_pin_analog,
  input wire logic        o_conv_done_flag
);
  // One clock domain for every check
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Bus request steps
  sequence s_wr(logic [2:0] a);
    i_wr && i_addr == a;
  endsequence
  sequence s_rd(logic [2:0] a);
    i_rd && i_addr == a;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_chan_follow: assert property (s_wr(SAS_OFF_CTRL) |=>
    o_channel_select == $past(i_wdata[5:2]))
    else $error("channel output differs from written field");
  chk_ref_bits: assert property (s_wr(SAS_OFF_REFPIN) |=>
    {o_neg_ref_select, o_pos_ref_select} == $past(i_wdata[5:4]))
    else $error("reference selects differ from written bits");
  chk_pin_digital: assert property (s_wr(SAS_OFF_REFPIN) ##0 i_wdata[3:0] == 4'hF |=>
    o_pin_analog == 13'h0000)
    else $error("pin code F leaves an analog pin");
  chk_pin_analog: assert property (s_wr(SAS_OFF_REFPIN) ##0 i_wdata[3:0] <= 4'h2 |=>
    o_pin_analog == 13'h1FFF)
    else $error("low pin code leaves a digital pin");
  chk_unused_bits: assert property (i_rd && i_addr <= SAS_OFF_REFPIN |=>
    o_rdata[7:6] == 2'b00)
    else $error("unimplemented control bits read nonzero");
  chk_timing_bit6: assert property (s_rd(SAS_OFF_TIMING) |=> !o_rdata[6])
    else $error("timing bit 6 reads nonzero");
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data nonzero outside a read answer");
  chk_flag_read: assert property (s_rd(SAS_OFF_FLAG) |=>
    o_rdata == {7'h00, $past(o_conv_done_flag)})
    else $error("flag read differs from flag output");
  chk_flag_sticky: assert property (o_conv_done_flag &&
    !(i_wr && i_addr == SAS_OFF_FLAG) |=> o_conv_done_flag)
    else $error("done flag dropped without a write");
  chk_flag_set: assert property (s_wr(SAS_OFF_FLAG) ##0 i_wdata[0] |=> o_conv_done_flag)
    else $error("flag write of one not seen");
  chk_unimpl_idle: assert property (o_channel_select > SAS_NUM_CH |-> !o_sample)
    else $error("sampling on an unimplemented channel");
  chk_reset_idle: assert property ($rose(i_rst_n) |-> !o_sample && !o_conv_done_flag)
    else $error("outputs not idle after reset");
endmodule

bind sas_top sas_top_props u_props (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_channel_select, .o_sample, .o_neg_ref_select, .o_pos_ref_select,
  .o_pin_analog, .o_conv_done_flag);

/* File: bench/sas_top_bench.sv */
// Self-checking bench for the converter sequencer top
`timescale 1ns/1ps
module sas_top_bench;
  import sas_pkg::*;
  // Design inputs and outputs
  logic        i_clk, i_rst_n, i_portb_analog_fuse, i_por, i_wr, i_rd, i_rc_osc, i_cmp;
  logic [2:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata;
  logic [9:0]  o_dac_code, target;
  logic [3:0]  o_channel_select;
  logic        o_sample, o_neg_ref_select, o_pos_ref_select, o_conv_done_flag;
  logic [12:0] o_pin_analog;
  logic [2:0]  rc_cnt = 3'h0;
  int          failures, n_checks, cyc;
  // Conversion table: timing byte, target, acquisition periods, clocks per period
  logic [7:0]  tims [5] = '{8'h14, 8'h81, 8'h11, 8'hB9, 8'h83};
  logic [9:0]  tgts [5] = '{10'h2D3, 10'h2A5, 10'h15A, 10'h3FF, 10'h001};
  int          acqs [5] = '{4, 0, 4, 20, 0};
  int          divs [5] = '{4, 8, 8, 8, 8};
  logic [7:0]  d, hi, lo;

  sas_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_portb_analog_fuse(i_portb_analog_fuse),
    .i_por(i_por), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_rc_osc(i_rc_osc), .i_cmp(i_cmp), .o_dac_code(o_dac_code),
    .o_channel_select(o_channel_select), .o_sample(o_sample),
    .o_neg_ref_select(o_neg_ref_select), .o_pos_ref_select(o_pos_ref_select),
    .o_pin_analog(o_pin_analog), .o_conv_done_flag(o_conv_done_flag));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, cycle count, RC oscillator of eight clocks, comparator of the input
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc      <= cyc + 1;
    rc_cnt   <= rc_cnt + 3'h1;
    i_rc_osc <= rc_cnt[2];
    i_cmp    <= (o_dac_code <= target);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 v = o_rdata;
  endtask
  // Start, poll to completion, check length, result pair, flag and hold-off
  task automatic convert(input logic [7:0] tim, input logic [9:0] tgt, input int exp_cyc);
    int t0;
    int k;
    target = tgt;
    wr(SAS_OFF_TIMING, tim);
    wr(SAS_OFF_CTRL, 8'h07);
    t0 = cyc;
    rd(SAS_OFF_CTRL, d);
    chk("start_busy", 13'(d[1]), 13'h1);
    if (tim[5:3] == 3'h0 && tim[1:0] != 2'h3)
      chk("sample_off", 13'(o_sample), 13'h0);
    for (k = 0; k < 300 && d[1] !== 1'b0; k++)
      rd(SAS_OFF_CTRL, d);
    chk("conv_len", 13'(cyc - t0 >= exp_cyc && cyc - t0 <= exp_cyc + 16), 13'h1);
    wr(SAS_OFF_CTRL, 8'h07);
    rd(SAS_OFF_CTRL, d);
    chk("holdoff", 13'(d), 13'h05);
    rd(SAS_OFF_RES_HI, hi);
    rd(SAS_OFF_RES_LO, lo);
    chk("res_hi", 13'(hi), tim[7] ? 13'(tgt[9:8]) : 13'(tgt[9:2]));
    chk("res_lo", 13'(lo), tim[7] ? 13'(tgt[7:0]) : 13'({tgt[1:0], 6'h00}));
    chk("dac_code", 13'(o_dac_code), 13'(tgt));
    chk("done_flag", 13'(o_conv_done_flag), 13'h1);
    wr(SAS_OFF_FLAG, 8'h00);
    repeat (24) @(posedge i_clk);
    chk("resample", 13'(o_sample), 13'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (30000) @(posedge i_clk);
    failures++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    {i_rst_n, i_por, i_wr, i_rd, i_cmp, i_rc_osc} = 6'h00;
    {i_addr, i_wdata, target, failures, n_checks} = '0;
    i_portb_analog_fuse = 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    // Reset values, unmapped reads
    for (int a = 0; a < 8; a++)
    begin
      if (a != 3 && a != 4)
      begin
        rd(3'(a), d);
        chk("reset_reg", 13'(d), 13'h0);
      end
    end
    chk("reset_pins", o_pin_analog, 13'h1FFF);
    wr(SAS_OFF_CTRL, 8'h02);
    rd(SAS_OFF_CTRL, d);
    chk("start_when_off", 13'(d), 13'h0);
    // Every channel code with the converter on
    for (int c = 0; c < 16; c++)
    begin
      wr(SAS_OFF_CTRL, 8'hC1 | 8'(c << 2));
      rd(SAS_OFF_CTRL, d);
      chk("ctrl_read", 13'(d), 13'(8'h01 | 8'(c << 2)));
      chk("channel", 13'(o_channel_select), 13'(c));
    end
    // Every pin code, reference bits taken from its two low bits
    for (int c = 0; c < 16; c++)
    begin
      wr(SAS_OFF_REFPIN, {2'b11, 1'(c), 1'(c >> 1), 4'(c)});
      rd(SAS_OFF_REFPIN, d);
      chk("ref_read", 13'(d), 13'({1'(c), 1'(c >> 1), 4'(c)}));
      chk("refs", 13'({o_neg_ref_select, o_pos_ref_select}), 13'({1'(c), 1'(c >> 1)}));
      chk("pins", o_pin_analog, (c <= 2) ? 13'h1FFF : 13'(13'h1FFF >> (c - 2)));
    end
    wr(SAS_OFF_TIMING, 8'hFF);
    rd(SAS_OFF_TIMING, d);
    chk("timing_read", 13'(d), 13'h0BF);
    wr(SAS_OFF_REFPIN, 8'h00);
    wr(SAS_OFF_CTRL, 8'h05);
    // Divider and RC conversions with three acquisition lengths
    for (int i = 0; i < 5; i++)
      convert(tims[i], tgts[i], (acqs[i] + 11) * divs[i] +
              ((tims[i][1:0] == 2'h3) ? int'(SAS_TCY_CYC) : 0));
    // Abort mid-conversion keeps the last result
    target = 10'h155;
    wr(SAS_OFF_TIMING, 8'hB9);
    wr(SAS_OFF_CTRL, 8'h07);
    repeat (200) @(posedge i_clk);
    wr(SAS_OFF_CTRL, 8'h05);
    rd(SAS_OFF_CTRL, d);
    chk("abort_ctrl", 13'(d), 13'h05);
    rd(SAS_OFF_RES_LO, lo);
    chk("abort_keep", 13'(lo), 13'h01);
    chk("abort_flag", 13'(o_conv_done_flag), 13'h0);
    // Reset in mid-acquisition: registers cleared, result pair kept
    repeat (16) @(posedge i_clk);
    wr(SAS_OFF_CTRL, 8'h07);
    repeat (50) @(posedge i_clk);
    rd(SAS_OFF_CTRL, d);
    chk("reset_busy", 13'(d[1]), 13'h1);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    rd(SAS_OFF_CTRL, d);
    chk("reset_ctrl", 13'(d), 13'h0);
    rd(SAS_OFF_RES_LO, lo);
    chk("reset_keep", 13'(lo), 13'h40);
    // Power-on reload with the fuse low
    i_portb_analog_fuse <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_por <= 1'b1;
    @(posedge i_clk);
    i_por <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(SAS_OFF_REFPIN, d);
    chk("por_ref", 13'(d), 13'h07);
    chk("por_pins", o_pin_analog, 13'h00FF);
    wr(SAS_OFF_FLAG, 8'h01);
    rd(SAS_OFF_FLAG, d);
    chk("flag_write", 13'(d), 13'h01);
    tally_and_finish();
  end
endmodule
